// [hw/ccc_alu.sv]
// Execution datapath for carry toggle, zero fill, invert and compare operations.
`timescale 1ns/1ps
module ccc_alu (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               start,
    input  wire ccc_pkg::ccc_instr_t instr,
    input  wire logic [3:0]         work_group,
    input  wire logic [7:0]         rd_data,
    output logic [7:0]              rd_addr,
    output ccc_pkg::ccc_write_t     wr,
    output logic [7:0]              flags,
    output logic                    busy,
    output logic                    done,
    output logic                    bad_opcode
);

    ////////////////////////////////////////////////////////////////////////////
    // Operand address decoding.

    function automatic logic [7:0] reg_addr(input logic [7:0] field, input logic [3:0] grp);
        if (field[7:4] == ccc_pkg::WORK_ESCAPE) begin
            reg_addr = {grp, field[3:0]};
        end else begin
            reg_addr = field;
        end
    endfunction : reg_addr

    typedef enum {st_idle, st_fetch_ptr, st_fetch_a, st_fetch_b, st_wait} ccc_state_t;

    ccc_state_t state;
    ccc_pkg::ccc_instr_t cur;
    logic [7:0] op_a;
    logic [3:0] count;
    logic       known;
    logic [3:0] len;

    always_comb begin
        known  = 1'b1;
        len    = ccc_pkg::CYC_SHORT;
        case (instr.opcode)
            ccc_pkg::OPC_CARRY_TOGGLE, ccc_pkg::OPC_ZERO_FILL_R, ccc_pkg::OPC_ZERO_FILL_PR,
            ccc_pkg::OPC_INVERT_R, ccc_pkg::OPC_INVERT_PR: len = ccc_pkg::CYC_SHORT;
            ccc_pkg::OPC_CMP_RR_W, ccc_pkg::OPC_CMP_RIR_W: begin
                len    = ccc_pkg::CYC_SHORT;
            end
            ccc_pkg::OPC_CMP_RR, ccc_pkg::OPC_CMP_RIR, ccc_pkg::OPC_CMP_RIM,
            ccc_pkg::OPC_CMP_IRIM: begin
                len    = ccc_pkg::CYC_LONG;
            end
            default: known = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic for the final step, operand b is the last byte read.

    logic [8:0] diff;
    logic [7:0] dst_val;
    logic [7:0] src_val;
    logic [7:0] inv_val;
    logic       src_first;

    // The A4 and A5 compare forms fetch the source first, so the operand order flips.
    assign src_first = (cur.opcode == ccc_pkg::OPC_CMP_RR) || (cur.opcode == ccc_pkg::OPC_CMP_RIR);
    always_comb begin
        dst_val = src_first ? rd_data : op_a;
        src_val = src_first ? op_a : rd_data;
        if (cur.opcode == ccc_pkg::OPC_CMP_RIM || cur.opcode == ccc_pkg::OPC_CMP_IRIM) begin
            dst_val = op_a;
            src_val = cur.byte2;
        end
    end
    assign diff    = {1'b0, dst_val} - {1'b0, src_val};
    assign inv_val = ~rd_data;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    // Fetch addresses: pointer forms other than A3 first read the pointer register.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state      <= st_idle;
            cur        <= '0;
            op_a       <= 8'h00;
            count      <= 4'h0;
            rd_addr    <= 8'h00;
            busy       <= 1'b0;
            done       <= 1'b0;
            bad_opcode <= 1'b0;
        end else begin
            done       <= 1'b0;
            bad_opcode <= 1'b0;
            case (state)
                st_idle: begin
                    if (start && !known) begin
                        bad_opcode <= 1'b1;
                    end else if (start) begin
                        cur   <= instr;
                        busy  <= 1'b1;
                        count <= len - 4'h1;
                        case (instr.opcode)
                            ccc_pkg::OPC_CARRY_TOGGLE, ccc_pkg::OPC_ZERO_FILL_R: begin
                                state <= st_wait;
                            end
                            ccc_pkg::OPC_INVERT_R: begin
                                rd_addr <= reg_addr(instr.byte1, work_group);
                                state   <= st_fetch_b;
                            end
                            ccc_pkg::OPC_CMP_RR_W, ccc_pkg::OPC_CMP_RIR_W: begin
                                rd_addr <= {work_group, instr.byte1[7:4]};
                                state   <= st_fetch_a;
                            end
                            ccc_pkg::OPC_CMP_RR, ccc_pkg::OPC_CMP_RIM: begin
                                rd_addr <= reg_addr(instr.byte1, work_group);
                                state   <= st_fetch_a;
                            end
                            default: begin
                                // B1, 61, A5 and A7 read a pointer in byte1 first.
                                rd_addr <= reg_addr(instr.byte1, work_group);
                                state   <= st_fetch_ptr;
                            end
                        endcase
                    end
                end
                st_fetch_ptr: begin
                    count   <= count - 4'h1;
                    rd_addr <= rd_data;
                    if (cur.opcode == ccc_pkg::OPC_CMP_RIR
                        || cur.opcode == ccc_pkg::OPC_CMP_IRIM) begin
                        state <= st_fetch_a;
                    end else begin
                        state <= st_fetch_b;
                    end
                end
                st_fetch_a: begin
                    count <= count - 4'h1;
                    op_a  <= rd_data;
                    state <= st_fetch_b;
                    if (cur.opcode == ccc_pkg::OPC_CMP_RR_W) begin
                        rd_addr <= {work_group, cur.byte1[3:0]};
                    end else if (cur.opcode == ccc_pkg::OPC_CMP_RIR_W) begin
                        rd_addr <= {work_group, cur.byte1[3:0]};
                        state   <= st_fetch_ptr;
                    end else if (cur.opcode == ccc_pkg::OPC_CMP_RR
                                 || cur.opcode == ccc_pkg::OPC_CMP_RIR) begin
                        rd_addr <= reg_addr(cur.byte2, work_group);
                    end
                end
                st_fetch_b: begin
                    count <= count - 4'h1;
                    state <= st_wait;
                end
                st_wait: begin
                    if (count <= 4'h1) begin
                        state <= st_idle;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Results: writes and flags land as the last operand arrives.

    logic fin;
    assign fin = (state == st_fetch_b) || (state == st_idle && start && known
                 && (instr.opcode == ccc_pkg::OPC_CARRY_TOGGLE
                     || instr.opcode == ccc_pkg::OPC_ZERO_FILL_R));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr <= '0;
        end else begin
            wr <= '0;
            if (state == st_idle && start && instr.opcode == ccc_pkg::OPC_ZERO_FILL_R) begin
                wr <= '{1'b1, reg_addr(instr.byte1, work_group), 8'h00};
            end else if (state == st_fetch_b && cur.opcode == ccc_pkg::OPC_ZERO_FILL_PR) begin
                wr <= '{1'b1, rd_addr, 8'h00};
            end else if (state == st_fetch_b && (cur.opcode == ccc_pkg::OPC_INVERT_R
                         || cur.opcode == ccc_pkg::OPC_INVERT_PR)) begin
                wr <= '{1'b1, rd_addr, inv_val};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            flags <= ccc_pkg::FLAGS_RESET;
        end else if (fin && state == st_idle && instr.opcode == ccc_pkg::OPC_CARRY_TOGGLE) begin
            flags[ccc_pkg::FLAG_C] <= ~flags[ccc_pkg::FLAG_C];
        end else if (state == st_fetch_b && (cur.opcode == ccc_pkg::OPC_INVERT_R
                     || cur.opcode == ccc_pkg::OPC_INVERT_PR)) begin
            flags[ccc_pkg::FLAG_Z] <= (inv_val == 8'h00);
            flags[ccc_pkg::FLAG_S] <= inv_val[7];
            flags[ccc_pkg::FLAG_V] <= 1'b0;
        end else if (state == st_fetch_b && cur.opcode[7:4] == 4'ha) begin
            flags[ccc_pkg::FLAG_C] <= diff[8];
            flags[ccc_pkg::FLAG_Z] <= (diff[7:0] == 8'h00);
            flags[ccc_pkg::FLAG_S] <= diff[7];
            flags[ccc_pkg::FLAG_V] <= (dst_val[7] != src_val[7]) && (diff[7] != dst_val[7]);
        end
    end

endmodule : ccc_alu

// [inc/ccc_pkg.sv]
// Package with opcodes, flag layout, cycle counts and shared types of the ALU block.
package ccc_pkg;

    // Opcodes handled by the block.
    localparam logic [7:0] OPC_CARRY_TOGGLE = 8'hef;
    localparam logic [7:0] OPC_ZERO_FILL_R  = 8'hb0;
    localparam logic [7:0] OPC_ZERO_FILL_PR = 8'hb1;
    localparam logic [7:0] OPC_INVERT_R     = 8'h60;
    localparam logic [7:0] OPC_INVERT_PR    = 8'h61;
    localparam logic [7:0] OPC_CMP_RR_W     = 8'ha2;
    localparam logic [7:0] OPC_CMP_RIR_W    = 8'ha3;
    localparam logic [7:0] OPC_CMP_RR       = 8'ha4;
    localparam logic [7:0] OPC_CMP_RIR      = 8'ha5;
    localparam logic [7:0] OPC_CMP_RIM      = 8'ha6;
    localparam logic [7:0] OPC_CMP_IRIM     = 8'ha7;

    // Working register escape in the high nibble of a register field.
    localparam logic [3:0] WORK_ESCAPE = 4'he;

    // Flag positions in the flag byte.
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;

    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // Execution length of each form in clock cycles.
    localparam logic [3:0] CYC_SHORT = 4'h6;
    localparam logic [3:0] CYC_LONG  = 4'ha;

    // Operand address modes.
    typedef enum logic [1:0] {
        working_mode,
        register_mode,
        pointer_register_mode,
        literal_operand_mode
    } ccc_mode_t;

    // An instruction handed to the block: opcode and up to two operand bytes.
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } ccc_instr_t;

    // A register file write request.
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } ccc_write_t;

endpackage : ccc_pkg

// [dv/ccc_alu_properties.sv]
// Checker with timing and flag properties of the ALU block.
`timescale 1ns/1ps
module ccc_alu_properties (
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic                start,
    input wire ccc_pkg::ccc_instr_t instr,
    input wire logic [3:0]          work_group,
    input wire logic [7:0]          rd_data,
    input wire logic [7:0]          rd_addr,
    input wire ccc_pkg::ccc_write_t wr,
    input wire logic [7:0]          flags,
    input wire logic                busy,
    input wire logic                done,
    input wire logic                bad_opcode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic       taken;
    logic       known;
    logic [7:0] op;
    logic [7:0] dst_map;
    assign taken = start && !busy;
    assign op = instr.opcode;
    assign known = (op inside {8'hef, 8'hb0, 8'hb1, 8'h60, 8'h61}) || (op >= 8'ha2 && op <= 8'ha7);
    assign dst_map = (instr.byte1[7:4] == ccc_pkg::WORK_ESCAPE) ? {work_group, instr.byte1[3:0]}
                                                                : instr.byte1;
    sequence short_run; ##1 !done [*5] ##1 done; endsequence
    sequence long_run; ##1 !done [*8] ##1 !done ##1 done; endsequence
    ////////////////////////////////////////////////////////////////////////////////
    short_len_a: assert property (
        taken && op inside {8'hef, 8'hb0, 8'hb1, 8'h60, 8'h61, 8'ha2, 8'ha3} |-> short_run)
        else $error("short form did not end after six cycles");
    long_len_a: assert property (
        taken && op >= 8'ha4 && op <= 8'ha7 |-> long_run) else $error("long form length wrong");
    carry_toggle_a: assert property (
        taken && op == 8'hef |=> flags == {~$past(flags[7]), $past(flags[6:0])})
        else $error("carry toggle flags wrong");
    fill_write_a: assert property (
        taken && op == 8'hb0 |=> wr.en && wr.addr == $past(dst_map) && wr.data == 8'h00)
        else $error("zero fill write wrong");
    fill_flags_a: assert property (
        taken && op inside {8'hb0, 8'hb1} |=> $stable(flags) [*6])
        else $error("zero fill moved flags");
    invert_result_a: assert property (
        taken && op == 8'h60 |=> ##1 wr.en && wr.data == ~$past(rd_data) && !flags[4]
        && flags[6] == (wr.data == 8'h00) && flags[5] == wr.data[7]
        && flags[7] == $past(flags[7], 2) && flags[3:2] == $past(flags[3:2], 2))
        else $error("invert result or flags wrong");
    ptr_invert_a: assert property (
        taken && op == 8'h61 |=> ##2 wr.en && wr.addr == $past(rd_data, 2)
        && wr.data == ~$past(rd_data) && !flags[4]) else $error("pointer invert wrong");
    // A new start is legal in the done cycle, so the quiet span ends there.
    short_cmp_quiet_a: assert property (
        taken && op inside {8'ha2, 8'ha3} |=> !wr.en [*6]) else $error("compare wrote back");
    compare_no_write_a: assert property (
        taken && op >= 8'ha4 && op <= 8'ha7 |=> !wr.en [*8] ##1 !wr.en ##1 !wr.en)
        else $error("long compare wrote back");
    busy_after_start_a: assert property (
        taken && known |=> busy && !bad_opcode) else $error("busy missing after start");
    bad_op_pulse_a: assert property (
        taken && !known |=> bad_opcode && !busy ##1 (!bad_opcode || $past(start)))
        else $error("bad opcode answer wrong");
endmodule : ccc_alu_properties

bind ccc_alu ccc_alu_properties u_props (.clk(clk), .nrst(nrst), .start(start), .instr(instr),
    .work_group(work_group), .rd_data(rd_data), .rd_addr(rd_addr), .wr(wr), .flags(flags),
    .busy(busy), .done(done), .bad_opcode(bad_opcode));

// [dv/tb_compare_complement_clear_alu.sv]
// Self-checking bench for the ALU block with a register file and reference model.
`timescale 1ns/1ps
module tb_compare_complement_clear_alu;
    logic                clk = 1'b0;
    logic                nrst = 1'b0;
    logic                start = 1'b0;
    ccc_pkg::ccc_instr_t instr = '0;
    logic [3:0]          work_group = 4'h0;
    logic [7:0]          rd_addr, flags, exp_flags;
    ccc_pkg::ccc_write_t wr;
    logic                busy, done, bad_opcode;
    logic [7:0]          mem [256];
    logic [7:0]          ref_mem [256];
    logic [7:0]          ops [12] = '{8'hef, 8'hb0, 8'hb1, 8'h60, 8'h61, 8'ha2, 8'ha3, 8'ha4,
                                     8'ha5, 8'ha6, 8'ha7, 8'h00};
    int                  error_cnt = 0;
    int                  checked = 0;
    always #5 clk = ~clk;
    ccc_alu DUT (.clk(clk), .nrst(nrst), .start(start), .instr(instr), .work_group(work_group),
        .rd_data(mem[rd_addr]), .rd_addr(rd_addr), .wr(wr), .flags(flags), .busy(busy),
        .done(done), .bad_opcode(bad_opcode));
    always @(posedge clk) if (wr.en === 1'b1) mem[wr.addr] <= wr.data;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // Escaped fields name a working register of the current group.
    function automatic logic [7:0] map(input logic [7:0] f, input logic [3:0] wg);
        return (f[7:4] == ccc_pkg::WORK_ESCAPE) ? {wg, f[3:0]} : f;
    endfunction : map
    task automatic run(input logic [7:0] op, b1, b2, input logic [3:0] wg);
        logic [7:0] d, s, a, r;
        int         n, cyc, bad;
        cyc = (op == 8'h00) ? 1 : 6;
        case (op)
            8'hef: exp_flags[7] = ~exp_flags[7];
            8'hb0, 8'hb1, 8'h60, 8'h61: begin
                a = op[0] ? ref_mem[map(b1, wg)] : map(b1, wg);
                r = op[6] ? ~ref_mem[a] : 8'h00;
                if (op[6]) exp_flags[6:4] = {r == 8'h00, r[7], 1'b0};
                ref_mem[a] = r;
            end
            8'ha2, 8'ha3: begin
                d = ref_mem[{wg, b1[7:4]}];
                s = ref_mem[{wg, b1[3:0]}];
                if (op[0]) s = ref_mem[s];
            end
            8'ha4, 8'ha5: begin
                s = ref_mem[map(b1, wg)];
                if (op[0]) s = ref_mem[s];
                d = ref_mem[map(b2, wg)];
            end
            8'ha6, 8'ha7: begin
                d = ref_mem[map(b1, wg)];
                if (op[0]) d = ref_mem[d];
                s = b2;
            end
            default: cyc = 1;
        endcase
        if (op[7:4] == 4'ha) begin
            cyc = op[2] ? 10 : 6;
            r = d - s;
            exp_flags[7:4] = {d < s, r == 8'h00, r[7],
                              (d[7] != s[7]) && (r[7] != d[7])};
        end
        @(posedge clk);
        start <= 1'b1;
        work_group <= wg;
        instr <= '{op, b1, b2};
        @(posedge clk);
        start <= 1'b0;
        n = 1;
        #1;
        check("busy", 8'(busy), 8'(cyc != 1));
        while (!(done === 1'b1 || bad_opcode === 1'b1) && n < 12) begin
            @(posedge clk);
            // A start while busy must be ignored, so the length must not change.
            start <= (n == 1) && (cyc > 1);
            #1;
            n++;
        end
        check("cycles", 8'(n), 8'(cyc));
        check("bad opcode", 8'(bad_opcode), 8'(cyc == 1));
        check("busy at end", 8'(busy), 8'h00);
        check("flags", flags, exp_flags);
        bad = 0;
        foreach (mem[i]) if (mem[i] !== ref_mem[i]) bad++;
        check("register file", 8'(bad), 8'h00);
    endtask : run
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(98));
        foreach (mem[i]) mem[i] = 8'($urandom);
        foreach (mem[i]) ref_mem[i] = mem[i];
        exp_flags = 8'h00;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        check("reset flags", flags, 8'h00);
        check("reset status", {4'h0, busy, done, bad_opcode, wr.en}, 8'h00);
        // Equal operands give the zero case that random data hardly reaches.
        run(8'ha6, 8'h6c, ref_mem[8'h6c], 4'h0);
        run(8'hef, 8'h00, 8'h00, 4'h0);
        for (int k = 0; k < 72; k++) begin
            logic [7:0] b1;
            b1 = 8'($urandom);
            if (b1[0]) b1[7:4] = 4'he;
            run(ops[k % 12], b1, 8'($urandom), 4'($urandom));
        end
        print_verdict();
    end
    initial begin
        #50000;
        error_cnt++;
        print_verdict();
    end
endmodule : tb_compare_complement_clear_alu
